// ==== include/l2dcc_pkg.sv ====
/*
  Package of the second-loop divider and calibration configuration bank:
  register offsets, field positions, reset values, state and carrier types.
  Assumes byte-wide registers addressed at their printed offsets.
*/
package l2dcc_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;
  localparam int DIV_W  = 18;
  localparam int SEL_W  = 3;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_REF_PRESCALE_CTRL = 9'h162;
  localparam logic [ADDR_W-1:0] OFS_CAL_DIV_HIGH      = 9'h163;
  localparam logic [ADDR_W-1:0] OFS_CAL_DIV_MID       = 9'h164;
  localparam logic [ADDR_W-1:0] OFS_CAL_DIV_LOW       = 9'h165;
  localparam logic [ADDR_W-1:0] OFS_FB_DIV_HIGH_CALDIS = 9'h166;
  localparam logic [ADDR_W-1:0] OFS_FB_DIV_MID        = 9'h167;
  localparam logic [ADDR_W-1:0] OFS_FB_DIV_LOW        = 9'h168;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int HIGH_DIV_MSB = 1;
  localparam int CALDIS_BIT   = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_REF_PRESCALE_CTRL = 8'h5D;
  localparam logic [1:0] RST_DIV_HIGH          = 2'h0;
  localparam logic [7:0] RST_DIV_MID           = 8'h00;
  localparam logic [7:0] RST_DIV_LOW           = 8'h0C;
  localparam logic       RST_CALDIS            = 1'b0;

  // ----------------------------------------------------------------
  // Mode codes
  // ----------------------------------------------------------------
  localparam logic [SEL_W-1:0] FB_SEL_CASCADED_ZD = 3'h1;
  localparam logic [SEL_W-1:0] FB_SEL_INTERNAL    = 3'h0;
  localparam logic [3:0]       PS_CODE0_RATIO     = 4'h8;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    L2DCC_IDLE = 2'b00,
    L2DCC_CAL  = 2'b01
  } l2dcc_cal_st_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } l2dcc_req_t;

  // Layout matches the prescaler / reference control register bit for bit
  typedef struct packed {
    logic [2:0] fb_prescaler_sel;
    logic [2:0] ref_freq_band;
    logic       crystal_amp_en;
    logic       ref_doubler_en;
  } l2dcc_cfg_t;

  // Prescaler code to divide ratio; code 0 divides by eight
  function automatic logic [3:0] l2dcc_ps_ratio(input logic [2:0] code);
    logic [3:0] r;
    r = {1'b0, code};
    if (code == 3'h0) begin
      r = PS_CODE0_RATIO;
    end else if (code == 3'h1) begin
      r = 4'h2;
    end
    return r;
  endfunction : l2dcc_ps_ratio

endpackage : l2dcc_pkg

// ==== logic/l2dcc_prescaler.sv ====
/*
  Feedback prescaler: divides the VCO tick stream by the selected code's ratio (code 0 gives 8, code 1 gives 2).
  Assumes vco_tick_in is a one-cycle enable synchronous to clk_in.
*/
`timescale 1ns/100ps
module l2dcc_prescaler (
  input  wire logic       clk_in,     // System clock
  input  wire logic       rst_b_in,   // Async reset, active low
  input  wire logic       ce_in,      // Clock enable
  input  wire logic       tick_in,    // VCO tick
  input  wire logic [2:0] sel_in,     // Prescaler code
  output logic            tick_out    // Prescaled tick
);

  typedef struct packed {
    logic [3:0] cnt;
    logic       tick;
  } l2dcc_ps_state_t;

  l2dcc_ps_state_t r;
  l2dcc_ps_state_t next_r;
  logic [3:0]      ratio;

  assign ratio    = l2dcc_pkg::l2dcc_ps_ratio(sel_in);
  assign tick_out = r.tick;

  always_comb begin
    next_r      = r;
    next_r.tick = 1'b0;
    if (tick_in) begin
      if (r.cnt + 4'h1 >= ratio) begin
        next_r.cnt  = 4'h0;
        next_r.tick = 1'b1;
      end else begin
        next_r.cnt = r.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      r <= '0;
    end else if (ce_in) begin
      r <= next_r;
    end
  end

endmodule : l2dcc_prescaler

// ==== logic/l2dcc_fb_divider.sv ====
/*
  Feedback divider: divides the prescaled tick by an 18-bit ratio.
  Assumes the ratio is stable between ticks; a ratio of zero stops output.
*/
`timescale 1ns/100ps
module l2dcc_fb_divider (
  input  wire logic        clk_in,    // System clock
  input  wire logic        rst_b_in,  // Async reset, active low
  input  wire logic        ce_in,     // Clock enable
  input  wire logic        tick_in,   // Prescaled tick
  input  wire logic [17:0] ratio_in,  // Divide ratio
  output logic             tick_out   // Feedback tick
);

  typedef struct packed {
    logic [17:0] cnt;
    logic        tick;
  } l2dcc_fd_state_t;

  l2dcc_fd_state_t r;
  l2dcc_fd_state_t next_r;

  assign tick_out = r.tick;

  always_comb begin
    next_r      = r;
    next_r.tick = 1'b0;
    if (ratio_in == 18'h00000) begin
      next_r.cnt = 18'h00000;
    end else if (tick_in) begin
      if (r.cnt >= ratio_in - 18'h00001) begin
        next_r.cnt  = 18'h00000;
        next_r.tick = 1'b1;
      end else begin
        next_r.cnt = r.cnt + 18'h00001;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      r <= '0;
    end else if (ce_in) begin
      r <= next_r;
    end
  end

endmodule : l2dcc_fb_divider

// ==== logic/l2dcc_bank.sv ====
/*
  Second-loop divider and calibration configuration bank: seven byte
  registers, frequency calibration launch and feedback ratio selection,
  with the prescaler and feedback divider attached.
  Assumes a plain register port synchronous to clk_in, a calibration engine
  that reports completion on cal_done_in, and VCO ticks as clock enables.
*/
// Behaviour
// - The feedback prescaler divides the VCO by 2,2,3,4,5,6,7 for codes 1-7 and by 8 for 0.
// - The crystal amplifier enable bit turns the oscillator amplifier on at 1 and off at 0.
// - The doubler enable bit turns the reference doubler on at 1 and bypasses it at 0.
// - Zero-delay feedback is never used while frequency calibration runs.
// - In cascaded zero-delay mode calibration uses the calibration divider as ratio.
// - When calibration finishes the ratio returns to the normal feedback divider.
// - Cascaded zero-delay mode is in force exactly when the feedback select equals 1.
// - The calibration divider is 18 bits over three bytes, top two bits lowest; 0 invalid.
// - Writing the feedback divider low byte starts calibration when disable is 0.
// - The calibration disable bit at 1 suppresses that launch and at 0 allows it.
// - The feedback divider is 18 bits over three bytes, top two bits lowest; 0 invalid.
`timescale 1ns/100ps
module l2dcc_bank (
  input  wire logic                   clk_in,              // System clock, 125 MHz
  input  wire logic                   rst_b_in,            // Async reset, active low
  input  wire logic                   ce_in,               // Clock enable
  input  wire l2dcc_pkg::l2dcc_req_t  req_in,              // Register access
  input  wire logic [2:0]             feedback_clk_sel_in, // Feedback clock select
  input  wire logic                   cal_done_in,         // Calibration finished
  input  wire logic                   vco_tick_in,         // Selected VCO tick
  output logic [7:0]                  rd_data_out,         // Read data
  output l2dcc_pkg::l2dcc_cfg_t       cfg_out,             // Reference controls
  output logic [17:0]                 fb_ratio_out,        // Active feedback ratio
  output logic                        cal_start_out,       // Calibration start
  output logic                        cal_busy_out,        // Calibration running
  output logic                        zero_delay_en_out,   // Zero-delay feedback on
  output logic                        fb_tick_out          // Feedback divider tick
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    l2dcc_pkg::l2dcc_cal_st_t st;
    l2dcc_pkg::l2dcc_cfg_t    cfg;
    logic [1:0]               cal_hi;
    logic [7:0]               cal_mid;
    logic [7:0]               cal_lo;
    logic [1:0]               fb_hi;
    logic                     caldis;
    logic [7:0]               fb_mid;
    logic [7:0]               fb_lo;
    logic [7:0]               rd_data;
    logic                     cal_start;
    logic [17:0]              fb_ratio;
    logic                     zd_en;
    logic                     busy;
  } l2dcc_state_t;

  l2dcc_state_t r;
  l2dcc_state_t next_r;
  logic         ps_tick;
  logic         launch;
  logic         cascaded;
  logic [17:0]  cal_div;
  logic [17:0]  fb_div;

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rd_data_out       = r.rd_data;
  assign cfg_out           = r.cfg;
  assign fb_ratio_out      = r.fb_ratio;
  assign cal_start_out     = r.cal_start;
  assign cal_busy_out      = r.busy;
  assign zero_delay_en_out = r.zd_en;

  // ----------------------------------------------------------------
  // Divider chain
  // ----------------------------------------------------------------
  l2dcc_prescaler u_prescaler (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .ce_in    (ce_in),
    .tick_in  (vco_tick_in),
    .sel_in   (r.cfg.fb_prescaler_sel),
    .tick_out (ps_tick)
  );

  l2dcc_fb_divider u_fb_divider (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .ce_in    (ce_in),
    .tick_in  (ps_tick),
    .ratio_in (r.fb_ratio),
    .tick_out (fb_tick_out)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r           = r;
    next_r.rd_data   = 8'h00;
    next_r.cal_start = 1'b0;
    launch           = 1'b0;

    // Register writes
    if (req_in.wr) begin
      unique case (req_in.addr)
        l2dcc_pkg::OFS_REF_PRESCALE_CTRL: begin
          next_r.cfg = req_in.wdata;
        end
        l2dcc_pkg::OFS_CAL_DIV_HIGH: begin
          next_r.cal_hi = req_in.wdata[l2dcc_pkg::HIGH_DIV_MSB:0];
        end
        l2dcc_pkg::OFS_CAL_DIV_MID: begin
          next_r.cal_mid = req_in.wdata;
        end
        l2dcc_pkg::OFS_CAL_DIV_LOW: begin
          next_r.cal_lo = req_in.wdata;
        end
        l2dcc_pkg::OFS_FB_DIV_HIGH_CALDIS: begin
          next_r.fb_hi  = req_in.wdata[l2dcc_pkg::HIGH_DIV_MSB:0];
          next_r.caldis = req_in.wdata[l2dcc_pkg::CALDIS_BIT];
        end
        l2dcc_pkg::OFS_FB_DIV_MID: begin
          next_r.fb_mid = req_in.wdata;
        end
        l2dcc_pkg::OFS_FB_DIV_LOW: begin
          next_r.fb_lo = req_in.wdata;
          launch = !r.caldis;
        end
        default: begin
          next_r.cfg = r.cfg;
        end
      endcase
    end

    // Register reads, answered in the following cycle
    if (req_in.rd) begin
      unique case (req_in.addr)
        l2dcc_pkg::OFS_REF_PRESCALE_CTRL: begin
          next_r.rd_data = r.cfg;
        end
        l2dcc_pkg::OFS_CAL_DIV_HIGH: begin
          next_r.rd_data = {6'h00, r.cal_hi};
        end
        l2dcc_pkg::OFS_CAL_DIV_MID: begin
          next_r.rd_data = r.cal_mid;
        end
        l2dcc_pkg::OFS_CAL_DIV_LOW: begin
          next_r.rd_data = r.cal_lo;
        end
        l2dcc_pkg::OFS_FB_DIV_HIGH_CALDIS: begin
          next_r.rd_data = {5'h00, r.caldis, r.fb_hi};
        end
        l2dcc_pkg::OFS_FB_DIV_MID: begin
          next_r.rd_data = r.fb_mid;
        end
        l2dcc_pkg::OFS_FB_DIV_LOW: begin
          next_r.rd_data = r.fb_lo;
        end
        default: begin
          next_r.rd_data = 8'h00;
        end
      endcase
    end

    // Calibration sequencer; a new launch wins over a finish
    unique case (r.st)
      l2dcc_pkg::L2DCC_IDLE: begin
        if (launch) begin
          next_r.st        = l2dcc_pkg::L2DCC_CAL;
          next_r.cal_start = 1'b1;
        end
      end
      l2dcc_pkg::L2DCC_CAL: begin
        if (launch) begin
          next_r.cal_start = 1'b1;
        end else if (cal_done_in) begin
          next_r.st = l2dcc_pkg::L2DCC_IDLE;
        end
      end
      default: begin
        next_r.st = l2dcc_pkg::L2DCC_IDLE;
      end
    endcase

    // Divider values including this cycle's writes
    cal_div = {next_r.cal_hi, next_r.cal_mid, next_r.cal_lo};
    fb_div  = {next_r.fb_hi, next_r.fb_mid, next_r.fb_lo};

    if (next_r.st == l2dcc_pkg::L2DCC_CAL && cascaded) begin
      next_r.fb_ratio = cal_div;
    end else begin
      next_r.fb_ratio = fb_div;
    end

    next_r.zd_en = (feedback_clk_sel_in != l2dcc_pkg::FB_SEL_INTERNAL)
                   && (next_r.st == l2dcc_pkg::L2DCC_IDLE);
    next_r.busy  = (next_r.st == l2dcc_pkg::L2DCC_CAL);
  end

  assign cascaded = (feedback_clk_sel_in == l2dcc_pkg::FB_SEL_CASCADED_ZD);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      r           <= '0;
      r.st        <= l2dcc_pkg::L2DCC_IDLE;
      r.cfg       <= l2dcc_pkg::RST_REF_PRESCALE_CTRL;
      r.cal_hi    <= l2dcc_pkg::RST_DIV_HIGH;
      r.cal_mid   <= l2dcc_pkg::RST_DIV_MID;
      r.cal_lo    <= l2dcc_pkg::RST_DIV_LOW;
      r.fb_hi     <= l2dcc_pkg::RST_DIV_HIGH;
      r.caldis    <= l2dcc_pkg::RST_CALDIS;
      r.fb_mid    <= l2dcc_pkg::RST_DIV_MID;
      r.fb_lo     <= l2dcc_pkg::RST_DIV_LOW;
      r.fb_ratio  <= {l2dcc_pkg::RST_DIV_HIGH, l2dcc_pkg::RST_DIV_MID,
                      l2dcc_pkg::RST_DIV_LOW};
    end else if (ce_in) begin
      r <= next_r;
    end
  end

endmodule : l2dcc_bank

// ==== verification/l2dcc_bank_assertions.sv ====
/*
  Checker for the second-loop divider bank: ties outputs to register writes.
  Assumes it is bound onto l2dcc_bank and sees only its ports.
*/
`timescale 1ns/100ps
module l2dcc_bank_checker (
  input wire logic                  clk_in,              // Clock
  input wire logic                  rst_b_in,            // Reset, active low
  input wire logic                  ce_in,               // Clock enable
  input wire l2dcc_pkg::l2dcc_req_t req_in,              // Register access
  input wire logic [2:0]            feedback_clk_sel_in, // Feedback select
  input wire logic                  cal_done_in,         // Calibration done
  input wire logic [7:0]            rd_data_out,         // Read data
  input wire l2dcc_pkg::l2dcc_cfg_t cfg_out,             // Reference controls
  input wire logic [17:0]           fb_ratio_out,        // Active ratio
  input wire logic                  cal_start_out,       // Calibration start
  input wire logic                  cal_busy_out,        // Calibration running
  input wire logic                  zero_delay_en_out    // Zero-delay on
);
  // ----------------------------------------------------------------
  // Shadow registers
  // ----------------------------------------------------------------
  logic [17:0] cal_q;
  logic [17:0] fb_q;
  logic        dis_q;
  logic        wr_ok;
  logic        launch;
  assign wr_ok  = req_in.wr && ce_in;
  assign launch = wr_ok && req_in.addr == l2dcc_pkg::OFS_FB_DIV_LOW;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cal_q <= 18'h0000C;
      fb_q  <= 18'h0000C;
      dis_q <= 1'b0;
    end else if (wr_ok) begin
      case (req_in.addr)
        l2dcc_pkg::OFS_CAL_DIV_HIGH: cal_q[17:16] <= req_in.wdata[1:0];
        l2dcc_pkg::OFS_CAL_DIV_MID:  cal_q[15:8] <= req_in.wdata;
        l2dcc_pkg::OFS_CAL_DIV_LOW:  cal_q[7:0] <= req_in.wdata;
        l2dcc_pkg::OFS_FB_DIV_HIGH_CALDIS: begin
          fb_q[17:16] <= req_in.wdata[1:0];
          dis_q       <= req_in.wdata[2];
        end
        l2dcc_pkg::OFS_FB_DIV_MID:   fb_q[15:8] <= req_in.wdata;
        l2dcc_pkg::OFS_FB_DIV_LOW:   fb_q[7:0] <= req_in.wdata;
        default: ;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  property p_cfg;
    wr_ok && req_in.addr == l2dcc_pkg::OFS_REF_PRESCALE_CTRL |=> cfg_out == $past(req_in.wdata);
  endproperty
  a_cfg: assert property (p_cfg) else $error("cfg_out differs from write");
  property p_cal_read;
    req_in.rd && ce_in && req_in.addr == l2dcc_pkg::OFS_CAL_DIV_LOW |=> rd_data_out == cal_q[7:0];
  endproperty
  a_cal_read: assert property (p_cal_read) else $error("cal low readback");
  property p_fb_read;
    req_in.rd && ce_in && req_in.addr == l2dcc_pkg::OFS_FB_DIV_HIGH_CALDIS
      |=> rd_data_out == {5'h00, dis_q, fb_q[17:16]};
  endproperty
  a_fb_read: assert property (p_fb_read) else $error("fb high readback");
  property p_start_cause;
    cal_start_out |-> cal_busy_out && $past(launch);
  endproperty
  a_start_cause: assert property (p_start_cause) else $error("start without launch");
  property p_launch;
    launch |=> cal_start_out == !dis_q;
  endproperty
  a_launch: assert property (p_launch) else $error("launch ignores disable bit");
  property p_no_zd;
    cal_busy_out |-> !zero_delay_en_out;
  endproperty
  a_no_zd: assert property (p_no_zd) else $error("zero delay during calibration");
  property p_cal_ratio;
    cal_busy_out && feedback_clk_sel_in == l2dcc_pkg::FB_SEL_CASCADED_ZD
      && $past(feedback_clk_sel_in) == l2dcc_pkg::FB_SEL_CASCADED_ZD |-> fb_ratio_out == cal_q;
  endproperty
  a_cal_ratio: assert property (p_cal_ratio) else $error("ratio not cal divider");
  property p_done;
    cal_busy_out && cal_done_in && ce_in && !wr_ok |=> !cal_busy_out ##0 fb_ratio_out == fb_q;
  endproperty
  a_done: assert property (p_done) else $error("ratio not restored after done");
  property p_zd_sel;
    !cal_busy_out && $past(ce_in) |-> zero_delay_en_out == ($past(feedback_clk_sel_in) != 3'h0);
  endproperty
  a_zd_sel: assert property (p_zd_sel) else $error("zero delay vs select");
endmodule : l2dcc_bank_checker

bind l2dcc_bank l2dcc_bank_checker u_chk (.clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(ce_in),
  .req_in(req_in), .feedback_clk_sel_in(feedback_clk_sel_in), .cal_done_in(cal_done_in),
  .rd_data_out(rd_data_out), .cfg_out(cfg_out), .fb_ratio_out(fb_ratio_out),
  .cal_start_out(cal_start_out), .cal_busy_out(cal_busy_out),
  .zero_delay_en_out(zero_delay_en_out));

// ==== verification/loop2_divider_cal_config_test.sv ====
/*
  Bench for the second-loop divider bank: reset values, access, prescaler
  ratios, calibration launch and ratio swap. Assumes a sole bus master.
*/
`timescale 1ns/100ps
module loop2_divider_cal_config_test;
  logic                  clk_in;
  logic                  rst_b_in;
  logic                  ce_in;
  l2dcc_pkg::l2dcc_req_t req_in;
  logic [2:0]            sel;
  logic                  cal_done;
  logic                  vco_tick;
  logic [7:0]            rd_data;
  l2dcc_pkg::l2dcc_cfg_t cfg;
  logic [17:0]           ratio;
  logic                  cal_start;
  logic                  cal_busy;
  logic                  zero_delay;
  logic                  fb_tick;
  logic [7:0]            got;
  int                    n_mismatch;
  int                    tests_run;
  int                    cycles = 0;

  l2dcc_bank uut (.clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(ce_in), .req_in(req_in),
    .feedback_clk_sel_in(sel), .cal_done_in(cal_done), .vco_tick_in(vco_tick),
    .rd_data_out(rd_data), .cfg_out(cfg), .fb_ratio_out(ratio), .cal_start_out(cal_start),
    .cal_busy_out(cal_busy), .zero_delay_en_out(zero_delay), .fb_tick_out(fb_tick));

  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  // ----------------------------------------------------------------
  // Bus and report tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [17:0] exp, input logic [17:0] seen);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wr_reg(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk_in);
    req_in <= {a, d, 1'b1, 1'b0};
    @(posedge clk_in);
    req_in.wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [8:0] a, output logic [7:0] d);
    @(posedge clk_in);
    req_in <= {a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_in);
    req_in.rd <= 1'b0;
    #1 d = rd_data;
  endtask : rd_reg
  task automatic end_of_test;
    if (n_mismatch == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    logic [7:0] exp [7] = '{8'h5D, 8'h00, 8'h00, 8'h0C, 8'h00, 8'h00, 8'h0C};
    check("cfg_out", 18'h0005D, 18'(cfg));
    for (int i = 0; i < 7; i++) begin
      rd_reg(l2dcc_pkg::OFS_REF_PRESCALE_CTRL + 9'(i), got);
      check("reset read", 18'(exp[i]), 18'(got));
    end
  endtask : t_reset
  task automatic t_access;
    logic [7:0] exp [8] = '{8'hFF, 8'h03, 8'hFF, 8'hFF, 8'h07, 8'hFF, 8'hFF, 8'h00};
    for (int i = 0; i < 8; i++) begin
      wr_reg(l2dcc_pkg::OFS_REF_PRESCALE_CTRL + 9'(i), 8'hFF);
      #1 check("cal_start_out", 18'h0, 18'(cal_start));
      rd_reg(l2dcc_pkg::OFS_REF_PRESCALE_CTRL + 9'(i), got);
      check("read back", 18'(exp[i]), 18'(got));
    end
    check("fb_ratio_out", 18'h3FFFF, ratio);
  endtask : t_access
  task automatic t_prescale;
    int exp_ps [8] = '{8, 2, 2, 3, 4, 5, 6, 7};
    int n;
    wr_reg(l2dcc_pkg::OFS_FB_DIV_HIGH_CALDIS, 8'h04);
    wr_reg(l2dcc_pkg::OFS_FB_DIV_MID, 8'h00);
    wr_reg(l2dcc_pkg::OFS_FB_DIV_LOW, 8'h01);
    for (int i = 0; i < 8; i++) begin
      wr_reg(l2dcc_pkg::OFS_REF_PRESCALE_CTRL, {3'(i), 5'h01});
      repeat (20) @(posedge clk_in);
      n = 0;
      do begin @(posedge clk_in); #1 n++; end while (fb_tick !== 1'b1 && n < 40);
      n = 0;
      do begin @(posedge clk_in); #1 n++; end while (fb_tick !== 1'b1 && n < 40);
      check("tick period", 18'(exp_ps[i]), 18'(n));
    end
  endtask : t_prescale
  task automatic finish_cal(input logic [17:0] exp_ratio, input logic exp_zd);
    @(posedge clk_in);
    cal_done <= 1'b1;
    @(posedge clk_in);
    cal_done <= 1'b0;
    #1 check("cal_busy_out", 18'h0, 18'(cal_busy));
    check("fb_ratio_out", exp_ratio, ratio);
    check("zero_delay_en_out", 18'(exp_zd), 18'(zero_delay));
  endtask : finish_cal
  task automatic t_cal;
    @(posedge clk_in);
    sel <= l2dcc_pkg::FB_SEL_CASCADED_ZD;
    wr_reg(l2dcc_pkg::OFS_CAL_DIV_HIGH, 8'h02);
    wr_reg(l2dcc_pkg::OFS_CAL_DIV_MID, 8'h03);
    wr_reg(l2dcc_pkg::OFS_CAL_DIV_LOW, 8'h45);
    wr_reg(l2dcc_pkg::OFS_FB_DIV_HIGH_CALDIS, 8'h01);
    wr_reg(l2dcc_pkg::OFS_FB_DIV_MID, 8'hAB);
    wr_reg(l2dcc_pkg::OFS_FB_DIV_LOW, 8'hCD);
    #1 check("cal_start_out", 18'h1, 18'(cal_start));
    check("fb_ratio_out", 18'h20345, ratio);
    check("zero_delay_en_out", 18'h0, 18'(zero_delay));
    repeat (5) @(posedge clk_in);
    #1 check("cal_busy_out", 18'h1, 18'(cal_busy));
    check("cal_start_out", 18'h0, 18'(cal_start));
    finish_cal(18'h1ABCD, 1'b1);
    @(posedge clk_in);
    sel <= 3'h2;
    wr_reg(l2dcc_pkg::OFS_FB_DIV_LOW, 8'hCD);
    #1 check("fb_ratio_out", 18'h1ABCD, ratio);
    finish_cal(18'h1ABCD, 1'b1);
    @(posedge clk_in);
    sel <= 3'h0;
    repeat (2) @(posedge clk_in);
    #1 check("zero_delay_en_out", 18'h0, 18'(zero_delay));
  endtask : t_cal
  task automatic t_freeze;
    @(posedge clk_in);
    ce_in <= 1'b0;
    wr_reg(l2dcc_pkg::OFS_REF_PRESCALE_CTRL, 8'h00);
    @(posedge clk_in);
    ce_in <= 1'b1;
    rd_reg(l2dcc_pkg::OFS_REF_PRESCALE_CTRL, got);
    check("frozen write", 18'h000E1, 18'(got));
  endtask : t_freeze
  // ----------------------------------------------------------------
  // Main sequence and timeout
  // ----------------------------------------------------------------
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  initial begin
    ce_in = 1'b1;
    req_in = '0;
    sel = 3'h0;
    cal_done = 1'b0;
    vco_tick = 1'b1;
    rst_b_in = 1'b0;
    n_mismatch = 0;
    tests_run = 0;
    repeat (10) @(posedge clk_in);
    rst_b_in <= 1'b1;
    t_reset();
    t_access();
    t_prescale();
    t_cal();
    t_freeze();
    end_of_test();
  end
endmodule : loop2_divider_cal_config_test
